/* File: hw/free_counter_defs.svh */
/*
  Offsets, field positions, reset values and timing figures of the
  free-running counter block.
  Assumes byte addresses on a 32-bit AHB-Lite bus, one word per register.
*/
`ifndef FREE_COUNTER_DEFS_SVH
`define FREE_COUNTER_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_COUNT_HIGH        8'h00
`define OFS_COUNT_LOW         8'h04
`define OFS_SHADOW_HIGH       8'h08
`define OFS_SHADOW_LOW        8'h0C
`define OFS_STATUS            8'h10
`define OFS_CONTROL_ONE       8'h14
`define OFS_CONTROL_TWO       8'h18
`define OFS_CONDITION_CODE    8'h1C
`define OFS_POWER             8'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_OVERFLOW_FLAG     0
`define BIT_OVERFLOW_IRQ_EN   0
`define BIT_PRESCALE_LSB      0
`define BIT_PRESCALE_MSB      1
`define BIT_EDGE_SELECT       2
`define BIT_IRQ_MASK          3
`define BIT_HALT              0
`define BIT_WAIT              1

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define COUNT_RELOAD          16'hFFFC
`define COUNT_TOP             16'hFFFF
`define RESET_CONTROL_TWO     8'h00
`define RESET_CONDITION_CODE  8'h08
`define EXT_MIN_EDGE_GAP      4

`endif

/* File: hw/free_counter_pkg.sv */
/*
  Types shared by the free-running counter modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package free_counter_pkg;

  typedef enum logic [1:0] {
    PRESCALE_DIV2 = 2'b00,
    PRESCALE_DIV4 = 2'b01,
    PRESCALE_DIV8 = 2'b10,
    PRESCALE_EXT  = 2'b11
  } prescale_sel_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_DATA = 2'b01
  } bus_state_t;

  typedef struct packed {
    logic [7:0] offset;
    logic       write;
  } bus_req_t;

  typedef struct packed {
    prescale_sel_t prescale;
    logic          edge_rise;
  } clk_cfg_t;

endpackage : free_counter_pkg

/* File: hw/ext_clock_sync.sv */
/*
  Synchroniser and active-edge detector for the external counter clock.
  Assumes the pin is asynchronous to ref_clk and slower than a quarter
  of it.
*/
`timescale 1ns/1ps
`default_nettype none

module ext_clock_sync
  import free_counter_pkg::*;
#(
  parameter bit PIN_BONDED = 1'b1
) (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic ext_clock_pin,
  input  wire logic edge_rise,
  output var  logic ext_tick
);

  logic       pin_level;
  logic       sync_first;
  logic       sync_second;
  logic       sync_prev;
  logic       rise_seen;
  logic       fall_seen;
  logic       active_edge;
  logic [1:0] settle;

  // Absent pin reads as constant one
  assign pin_level = PIN_BONDED ? ext_clock_pin : 1'b1;
  assign rise_seen = sync_second & ~sync_prev;
  assign fall_seen = ~sync_second & sync_prev;
  assign active_edge = edge_rise ? rise_seen : fall_seen;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync_first  <= 1'b1;
      sync_second <= 1'b1;
      sync_prev   <= 1'b1;
      settle      <= 2'h0;
      ext_tick    <= 1'b0;
    end else begin
      sync_first  <= pin_level;
      sync_second <= sync_first;
      sync_prev   <= sync_second;
      if (settle != 2'h3) begin
        settle <= settle + 2'h1;
      end
      // No edge until both stages hold real pin levels
      ext_tick    <= (settle == 2'h3) & active_edge;
    end
  end

endmodule : ext_clock_sync

`default_nettype wire

/* File: hw/count_tick_gen.sv */
/*
  Prescaler and clock selection: one-cycle count enables at ref_clk/2,
  /4, /8 or on each synchronised external edge.
  Assumes ext_tick is already synchronous to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module count_tick_gen
  import free_counter_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          reset,
  input  wire logic          run,
  input  wire logic          restart,
  input  wire prescale_sel_t prescale,
  input  wire logic          ext_tick,
  output var  logic          count_tick
);

  logic [2:0] div_cnt;
  logic [2:0] div_mask;
  logic       div_hit;
  logic       pick;

  assign div_mask = (prescale == PRESCALE_DIV2) ? 3'h1 :
                    (prescale == PRESCALE_DIV4) ? 3'h3 : 3'h7;
  assign div_hit  = (div_cnt & div_mask) == div_mask;
  // External source chosen when both select bits are set
  assign pick = (prescale == PRESCALE_EXT) ? ext_tick : div_hit;

  always_ff @(posedge ref_clk) begin
    if (reset || restart) begin
      div_cnt    <= 3'h0;
      count_tick <= 1'b0;
    end else if (run) begin
      div_cnt    <= div_cnt + 3'h1;
      count_tick <= pick;
    end else begin
      count_tick <= 1'b0;
    end
  end

endmodule : count_tick_gen

`default_nettype wire

/* File: hw/free_counter.sv */
/*
  16-bit free-running up-counter with prescaler, external clock input,
  two read views, low-byte buffering, overflow flag and interrupt, and
  halt/wait handling, reached over an AHB-Lite slave port.
  Assumes one AHB-Lite master, single word transfers, and ext_clock_pin
  asynchronous to ref_clk.
*/
// Contract
// - sixteen-bit up counter, high and low bytes
// - count at clock/2, /4, /8 or external
// - low-byte writes force count to FFFC
// - reset and reload value is FFFC
// - shadow view equal, never clears flag
// - high read first latches low byte
// - latched low frozen until low read
// - lone low read returns live byte
// - wrap FFFF to 0000 sets flag
// - interrupt needs enable and clear mask
// - status read then low access clears
// - wait mode changes nothing
// - halt freezes, resumes or restarts
// - code 11 selects external clock
// - edge select picks active pin edge
// - external ticks resynchronised to cpu clock
// - absent pin reads as one
`timescale 1ns/1ps
`default_nettype none
`include "free_counter_defs.svh"

module free_counter
  import free_counter_pkg::*;
#(
  parameter bit EXT_PIN_BONDED = 1'b1
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  input  wire logic        ext_clock_pin,
  input  wire logic        wake_request,
  output var  logic        overflow_irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  bus_state_t  bus_state;
  bus_req_t    req;
  logic [15:0] count;
  logic [7:0]  low_buffer;
  logic        read_pending;
  logic        overflow_flag;
  logic        clear_armed;
  logic        overflow_irq_enable;
  clk_cfg_t    clk_cfg;
  logic        irq_mask;
  logic        halt_mode;
  logic        wait_mode;

  // ----------------------------------------------------------------
  // Decode of the data phase
  // ----------------------------------------------------------------
  logic        addr_take;
  logic        act;
  logic        act_rd;
  logic        act_wr;
  logic        hit_high;
  logic        hit_low;
  logic        hit_shadow_high;
  logic        hit_shadow_low;
  logic        hit_status;
  logic        hit_ctrl_one;
  logic        hit_ctrl_two;
  logic        hit_cc;
  logic        hit_power;
  logic        any_high_rd;
  logic        any_low_rd;
  logic        main_low_access;
  logic        low_write;
  logic [7:0]  low_view;
  logic [7:0]  read_byte;
  logic        wrap;
  logic        count_tick;
  logic        ext_tick;
  logic        run;
  logic        open_seq;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  assign addr_take = hsel & htrans[1] & hready;
  assign act       = (bus_state == BUS_DATA);
  assign act_rd    = act & ~req.write;
  assign act_wr    = act & req.write;

  assign hit_high        = hit(req.offset, `OFS_COUNT_HIGH);
  assign hit_low         = hit(req.offset, `OFS_COUNT_LOW);
  assign hit_shadow_high = hit(req.offset, `OFS_SHADOW_HIGH);
  assign hit_shadow_low  = hit(req.offset, `OFS_SHADOW_LOW);
  assign hit_status      = hit(req.offset, `OFS_STATUS);
  assign hit_ctrl_one    = hit(req.offset, `OFS_CONTROL_ONE);
  assign hit_ctrl_two    = hit(req.offset, `OFS_CONTROL_TWO);
  assign hit_cc          = hit(req.offset, `OFS_CONDITION_CODE);
  assign hit_power       = hit(req.offset, `OFS_POWER);

  // Both views read the same count
  assign any_high_rd = act_rd & (hit_high | hit_shadow_high);
  assign any_low_rd  = act_rd & (hit_low | hit_shadow_low);
  // Only the main low byte takes part in clearing the flag
  assign main_low_access = act & hit_low;
  assign low_write = act_wr & (hit_low | hit_shadow_low);
  // High read opens a sequence only when none is open
  assign open_seq = any_high_rd & ~read_pending;

  // Buffered byte while a sequence is open, live byte otherwise
  assign low_view = read_pending ? low_buffer : count[7:0];

  assign wrap = count_tick & (count == `COUNT_TOP);

  assign read_byte =
      (hit_high | hit_shadow_high) ? count[15:8] :
      (hit_low | hit_shadow_low)   ? low_view :
      hit_status   ? {7'h00, overflow_flag} :
      hit_ctrl_one ? {7'h00, overflow_irq_enable} :
      hit_ctrl_two ? {5'h00, clk_cfg.edge_rise, clk_cfg.prescale} :
      hit_cc       ? {4'h0, irq_mask, 3'h0} :
      hit_power    ? {6'h00, wait_mode, halt_mode} : 8'h00;

  // Halt freezes prescaler and counter; wait has no effect
  assign run = ~halt_mode;

  // ----------------------------------------------------------------
  // Clock path
  // ----------------------------------------------------------------
  // Pin edges counted only after resampling on ref_clk
  ext_clock_sync #(
    .PIN_BONDED (EXT_PIN_BONDED)
  ) u_ext_sync (
    .ref_clk       (ref_clk),
    .reset         (reset),
    .ext_clock_pin (ext_clock_pin),
    .edge_rise     (clk_cfg.edge_rise),
    .ext_tick      (ext_tick)
  );

  count_tick_gen u_tick (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .run        (run),
    .restart    (low_write),
    .prescale   (clk_cfg.prescale),
    .ext_tick   (ext_tick),
    .count_tick (count_tick)
  );

  // ----------------------------------------------------------------
  // AHB-Lite slave: one wait state, data from flops
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bus_state  <= BUS_IDLE;
      req        <= '0;
      hreadyout  <= 1'b1;
      hrdata     <= 32'h0000_0000;
      hresp      <= 1'b0;
    end else begin
      case (bus_state)
        BUS_IDLE: begin
          if (addr_take) begin
            bus_state  <= BUS_DATA;
            req.offset <= haddr[7:0];
            req.write  <= hwrite;
            hreadyout  <= 1'b0;
          end
        end
        BUS_DATA: begin
          bus_state <= BUS_IDLE;
          hreadyout <= 1'b1;
          hrdata    <= req.write ? 32'h0000_0000 : {24'h000000, read_byte};
        end
        default: begin
          bus_state <= BUS_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count <= `COUNT_RELOAD;
    end else if (low_write) begin
      count <= `COUNT_RELOAD;
    end else if (count_tick) begin
      count <= count + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // 16-bit read sequence
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      low_buffer   <= 8'h00;
      read_pending <= 1'b0;
    end else if (open_seq) begin
      low_buffer   <= count[7:0];
      read_pending <= 1'b1;
    end else if (any_low_rd) begin
      read_pending <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Overflow flag
  // ----------------------------------------------------------------
  logic        flag_clear;
  logic        arm_clear;
  logic        irq_due;

  assign flag_clear = main_low_access & clear_armed;
  assign arm_clear  = act_rd & hit_status & overflow_flag;
  // Stays pending until enable set and mask clear
  assign irq_due = overflow_flag & overflow_irq_enable & ~irq_mask;

  // Set wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      overflow_flag <= 1'b0;
    end else if (wrap) begin
      overflow_flag <= 1'b1;
    end else if (flag_clear) begin
      overflow_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Clear sequence: status read with flag set, then low access
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      clear_armed <= 1'b0;
    end else if (arm_clear) begin
      clear_armed <= 1'b1;
    end else if (main_low_access) begin
      clear_armed <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Overflow interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      overflow_irq <= 1'b0;
    end else begin
      overflow_irq <= irq_due;
    end
  end

  // ----------------------------------------------------------------
  // Control register strobes
  // ----------------------------------------------------------------
  logic        wr_ctrl_one;
  logic        wr_ctrl_two;
  logic        wr_cc;
  logic        wr_power;
  logic        next_halt_mode;

  assign wr_ctrl_one = act_wr & hit_ctrl_one;
  assign wr_ctrl_two = act_wr & hit_ctrl_two;
  assign wr_cc       = act_wr & hit_cc;
  assign wr_power    = act_wr & hit_power;

  // Wake by interrupt resumes from the held count
  assign next_halt_mode = (wake_request | overflow_irq) ? 1'b0 :
                          wr_power ? hwdata[`BIT_HALT] : halt_mode;

  // ----------------------------------------------------------------
  // Interrupt enable
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      overflow_irq_enable <= 1'b0;
    end else if (wr_ctrl_one) begin
      overflow_irq_enable <= hwdata[`BIT_OVERFLOW_IRQ_EN];
    end
  end

  // ----------------------------------------------------------------
  // Clock selection
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      clk_cfg <= clk_cfg_t'(`RESET_CONTROL_TWO);
    end else if (wr_ctrl_two) begin
      clk_cfg.prescale  <= prescale_sel_t'(
                             hwdata[`BIT_PRESCALE_MSB:`BIT_PRESCALE_LSB]);
      clk_cfg.edge_rise <= hwdata[`BIT_EDGE_SELECT];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt mask
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_mask <= 1'(`RESET_CONDITION_CODE >> `BIT_IRQ_MASK);
    end else if (wr_cc) begin
      irq_mask <= hwdata[`BIT_IRQ_MASK];
    end
  end

  // ----------------------------------------------------------------
  // Power modes
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      halt_mode <= 1'b0;
      wait_mode <= 1'b0;
    end else begin
      halt_mode <= next_halt_mode;
      // Wait is only stored; counting goes on
      if (wr_power) begin
        wait_mode <= hwdata[`BIT_WAIT];
      end
    end
  end

endmodule : free_counter

`default_nettype wire

/* File: bench/free_counter_assertions.sv */
/*
  Checker of the free_counter bus port and overflow interrupt.
  Assumes hready is fed from the slave's own hreadyout.
*/
`timescale 1ns/1ps
`default_nettype none
`include "free_counter_defs.svh"

module free_counter_assertions (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        overflow_irq
);
  // ------
  // Transfer tracking
  // ------
  logic       pend;
  logic       wr;
  logic [7:0] ofs;
  logic       en_q;
  logic       mask_q;
  logic [3:0] since;
  wire        take = hsel && htrans[1] && hready;
  wire        done = pend && !hreadyout;
  wire        wdone = done && wr;
  wire        ctl = ofs == `OFS_CONTROL_ONE || ofs == `OFS_CONDITION_CODE;
  wire        clr = done && (ofs == `OFS_COUNT_LOW || (wr && ctl));

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pend   <= 1'h0;
      en_q   <= 1'h0;
      mask_q <= 1'h1;
      since  <= 4'hF;
    end else begin
      pend  <= take || (pend && !done);
      since <= clr ? 4'h0 : since + {3'h0, since != 4'hF};
      if (take) begin
        wr  <= hwrite;
        ofs <= haddr[7:0];
      end
      if (wdone && ofs == `OFS_CONTROL_ONE)
        en_q <= hwdata[`BIT_OVERFLOW_IRQ_EN];
      if (wdone && ofs == `OFS_CONDITION_CODE)
        mask_q <= hwdata[`BIT_IRQ_MASK];
    end
  end

  // ------
  // Properties
  // ------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  chk_one_wait: assert property (take |=> !hreadyout ##1 hreadyout)
    else $error("transfer not answered after one wait");
  chk_wait_cause: assert property ($fell(hreadyout) |-> $past(take))
    else $error("wait state without transfer");
  chk_upper_zero: assert property (done && !wr |=> hrdata[31:8] == 24'h0)
    else $error("read data above byte not zero");
  chk_data_holds: assert property ($changed(hrdata) |-> $past(done))
    else $error("read data changed outside transfer");
  chk_unmapped_zero: assert property (
    done && !wr && ofs > `OFS_POWER |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_irq_gated: assert property (overflow_irq |->
    (en_q || $past(en_q)) && (!mask_q || !$past(mask_q)))
    else $error("interrupt while disabled or masked");
  chk_irq_clear: assert property ($fell(overflow_irq) |-> since <= 4'h3)
    else $error("interrupt dropped without clearing access");
  chk_reset_idle: assert property (disable iff (1'b0) reset |=>
    hreadyout && !hresp && !overflow_irq && hrdata == 32'h0)
    else $error("outputs not idle in reset");

  cov_write: cover property (take && hwrite);
  cov_irq_up: cover property ($rose(overflow_irq));
  cov_irq_down: cover property ($fell(overflow_irq));
endmodule : free_counter_assertions

bind free_counter free_counter_assertions u_chk (
  .ref_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hrdata, .hreadyout, .hresp, .overflow_irq
);
`default_nettype wire

/* File: bench/tb.sv */
/*
  Self-checking bench of free_counter: count views, clock sources,
  overflow flag and interrupt, wait and halt.
  Assumes the checker is bound to the design from its own file.
*/
`timescale 1ns/1ps
`default_nettype none
`include "free_counter_defs.svh"

module tb
  import free_counter_pkg::*;
;
  logic          ref_clk = 1'h0;
  logic          reset   = 1'h1;
  logic          hsel    = 1'h0;
  logic [31:0]   haddr   = 32'h0;
  logic [1:0]    htrans  = 2'h0;
  logic          hwrite  = 1'h0;
  logic [31:0]   hwdata  = 32'h0;
  logic          ext_clock_pin = 1'h0;
  logic          wake_request  = 1'h0;
  logic [31:0]   hrdata;
  logic          hreadyout;
  logic          hresp;
  logic          overflow_irq;
  logic [31:0]   q;
  logic [7:0]    v;
  logic [15:0]   lf = 16'h0059;
  int            bad_count  = 0;
  int            num_checks = 0;
  int            k;
  prescale_sel_t sel [3] = '{PRESCALE_DIV2, PRESCALE_DIV4, PRESCALE_DIV8};

  free_counter dut (
    .ref_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .ext_clock_pin, .wake_request, .overflow_irq
  );

  initial forever #12.5 ref_clk = ~ref_clk;

  // ------
  // Helpers
  // ------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic [31:0] cnt_lo(input int n);
    logic [15:0] c;
    c = `COUNT_RELOAD + n[15:0];
    return {24'h0, c[7:0]};
  endfunction : cnt_lo

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  task automatic check(input string n, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : check

  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'h1 && n < 40);
    if (hreadyout !== 1'h1) begin
      bad_count++;
      end_of_test();
    end
  endtask : wait_ready

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    lf = lfsr(lf);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    wait_ready();
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {lf, 8'h0, d};
    wait_ready();
    q = hrdata;
  endtask : bus

  task automatic rx(input logic [7:0] a, input logic [31:0] e, string n);
    bus(1'h0, a, 8'h0);
    check(n, q, e);
  endtask : rx

  task automatic lvl(input logic b);
    ext_clock_pin <= b;
    repeat (8) @(posedge ref_clk);
  endtask : lvl

  task automatic restart;
    reset <= 1'h1;
    repeat (5) @(posedge ref_clk);
    reset <= 1'h0;
    @(posedge ref_clk);
    rx(`OFS_STATUS, 32'h0, "status");
    rx(`OFS_COUNT_HIGH, 32'hFF, "high");
    bus(1'h0, `OFS_COUNT_LOW, 8'h0);
    check("low", {26'h0, q[7:2]}, 32'h3F);
    $display("test reset ended");
  endtask : restart

  // ------
  // Main sequence
  // ------
  initial begin
    restart();
    rx(`OFS_CONTROL_TWO, `RESET_CONTROL_TWO, "ctl2");
    rx(`OFS_CONDITION_CODE, `RESET_CONDITION_CODE, "cc");
    bus(1'h1, 8'h28, 8'h5A);
    rx(8'h24, 32'h0, "unmapped");
    bus(1'h1, `OFS_CONTROL_TWO, {5'h0, 1'h1, PRESCALE_EXT});
    bus(1'h0, `OFS_STATUS, 8'h0);
    bus(1'h1, `OFS_COUNT_LOW, lf[7:0]);
    rx(`OFS_STATUS, 32'h0, "status");
    rx(`OFS_COUNT_HIGH, 32'hFF, "high");
    rx(`OFS_COUNT_LOW, cnt_lo(0), "low");
    lvl(1'h1);
    rx(`OFS_SHADOW_LOW, cnt_lo(1), "live");
    rx(`OFS_COUNT_HIGH, 32'hFF, "high");
    lvl(1'h0);
    lvl(1'h1);
    rx(`OFS_COUNT_HIGH, 32'hFF, "high again");
    rx(`OFS_COUNT_LOW, cnt_lo(1), "latched");
    rx(`OFS_SHADOW_LOW, cnt_lo(2), "live");
    rx(`OFS_SHADOW_HIGH, 32'hFF, "shadow high");
    rx(`OFS_SHADOW_LOW, cnt_lo(2), "shadow low");
    $display("test read views ended");
    bus(1'h1, `OFS_CONTROL_ONE, 8'h01);
    bus(1'h1, `OFS_CONDITION_CODE, 8'h00);
    lvl(1'h0);
    lvl(1'h1);
    rx(`OFS_STATUS, 32'h0, "status at top");
    lvl(1'h0);
    lvl(1'h1);
    rx(`OFS_STATUS, 32'h1, "status wrap");
    check("irq", {31'h0, overflow_irq}, 32'h1);
    rx(`OFS_SHADOW_HIGH, 32'h0, "shadow high");
    rx(`OFS_SHADOW_LOW, 32'h0, "shadow low");
    rx(`OFS_STATUS, 32'h1, "status kept");
    rx(`OFS_COUNT_LOW, 32'h0, "low");
    rx(`OFS_STATUS, 32'h0, "status cleared");
    check("irq", {31'h0, overflow_irq}, 32'h0);
    bus(1'h1, `OFS_CONDITION_CODE, 8'h08);
    bus(1'h1, `OFS_COUNT_LOW, lf[7:0]);
    repeat (4) begin
      lvl(1'h0);
      lvl(1'h1);
    end
    check("irq masked", {31'h0, overflow_irq}, 32'h0);
    bus(1'h1, `OFS_CONDITION_CODE, 8'h00);
    repeat (2) @(posedge ref_clk);
    check("irq pending", {31'h0, overflow_irq}, 32'h1);
    rx(`OFS_STATUS, 32'h1, "status");
    bus(1'h1, `OFS_COUNT_LOW, lf[7:0]);
    rx(`OFS_STATUS, 32'h0, "status cleared");
    $display("test overflow ended");
    bus(1'h1, `OFS_POWER, 8'h02);
    lvl(1'h0);
    lvl(1'h1);
    rx(`OFS_SHADOW_LOW, cnt_lo(1), "wait count");
    bus(1'h1, `OFS_POWER, 8'h01);
    lvl(1'h0);
    lvl(1'h1);
    rx(`OFS_SHADOW_LOW, cnt_lo(1), "halt count");
    wake_request <= 1'h1;
    @(posedge ref_clk);
    wake_request <= 1'h0;
    lvl(1'h0);
    lvl(1'h1);
    rx(`OFS_SHADOW_LOW, cnt_lo(2), "woken count");
    bus(1'h1, `OFS_CONTROL_TWO, {6'h0, PRESCALE_EXT});
    bus(1'h1, `OFS_COUNT_LOW, lf[7:0]);
    lvl(1'h0);
    rx(`OFS_SHADOW_LOW, cnt_lo(1), "fall edge");
    lvl(1'h1);
    rx(`OFS_SHADOW_LOW, cnt_lo(1), "rise ignored");
    $display("test power and edges ended");
    for (int c = 0; c < 3; c++) begin
      k = 4 + int'(lf[1:0]);
      bus(1'h1, `OFS_CONTROL_TWO, {6'h0, sel[c]});
      bus(1'h0, `OFS_SHADOW_LOW, 8'h0);
      v = q[7:0];
      repeat ((2 << c) * k - 3) @(posedge ref_clk);
      bus(1'h0, `OFS_SHADOW_LOW, 8'h0);
      check("ticks", {24'h0, q[7:0] - v}, k);
    end
    $display("test prescaler ended");
    bus(1'h1, `OFS_CONTROL_ONE, 8'h00);
    bus(1'h1, `OFS_POWER, 8'h01);
    rx(`OFS_POWER, 32'h1, "halted");
    restart();
    end_of_test();
  end
endmodule : tb
`default_nettype wire
